// *** core/pport_pkg.sv ***
// Shared constants for the printer-port pin-share link
package pport_pkg;
  // Control bit positions (software-facing register bits of our own)
  localparam int ECP_EN_BIT     = 2;   // Port control: extended mode enable
  localparam int DMA_CFG_BIT    = 3;   // Power management: DMA configured
  localparam int PNF_EN_BIT     = 2;   // Floppy config: pin is selector
  localparam int SEL_CTRL_BIT   = 3;   // Port control: select-input drive
  // Own register offsets on the plain software port
  localparam logic [3:0] OFS_PORT_CTRL  = 4'h0;
  localparam logic [3:0] OFS_PWR_MGMT   = 4'h1;
  localparam logic [3:0] OFS_FLOPPY_CFG = 4'h2;
  localparam logic [3:0] OFS_STATUS     = 4'h3;
  localparam logic [3:0] OFS_DATA       = 4'h4;
  // Reset values
  localparam logic [7:0] PORT_CTRL_RST  = 8'h00;
  localparam logic [7:0] PWR_MGMT_RST   = 8'h00;
  localparam logic [7:0] FLOPPY_CFG_RST = 8'h00;
  // Buffer shape
  localparam int FIFO_DEPTH = 8;
  localparam int DATA_W     = 8;
endpackage

// *** core/pport_if.sv ***
// Pin-level link between printer port and DMA controller / printer
`timescale 1ns/1ps
interface pport_if;
  logic       printer_dma_req;       // Request level from device
  logic       printer_dma_req_oe;    // Device drives request pin
  logic       shared_ack_pin;        // Acknowledge / identity pin
  logic       dma_rd_n;              // Read strobe, active low
  logic       dma_wr_n;              // Write strobe, active low
  logic [7:0] port_data_out;         // Data driven by device
  logic [7:0] port_data_oe;          // Per-bit drive enable
  logic       paper_end;             // Printer out of paper
  logic       printer_selected;      // Printer connected
  logic       select_input_n_out;    // Select-input level
  logic       select_input_n_oe;     // Select-input driven
  logic       printer_not_floppy_sel;// Selector / drive-two pin
  logic       floppy_rdata;          // Raw read data from drive
  logic [7:0] dma_data;              // Data from host on DMA write
  modport device
  (
    output printer_dma_req, printer_dma_req_oe, port_data_out,
           port_data_oe, select_input_n_out, select_input_n_oe,
    input  shared_ack_pin, dma_rd_n, dma_wr_n, paper_end,
           printer_selected, printer_not_floppy_sel, floppy_rdata,
           dma_data
  );
  modport host
  (
    input  printer_dma_req, printer_dma_req_oe, port_data_out,
           port_data_oe, select_input_n_out, select_input_n_oe,
    output shared_ack_pin, dma_rd_n, dma_wr_n, paper_end,
           printer_selected, printer_not_floppy_sel, floppy_rdata,
           dma_data
  );
endinterface // pport_if

// *** core/pport_fifo.sv ***
// Parameterised valid/ready FIFO for the printer data path
`timescale 1ns/1ps
module pport_fifo #(
  parameter int WIDTH = pport_pkg::DATA_W,
  parameter int DEPTH = pport_pkg::FIFO_DEPTH
)(
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             clk_en,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];        // Word storage
  logic [AW-1:0]    wr_ptr;             // Write index
  logic [AW-1:0]    rd_ptr;             // Read index
  logic [AW:0]      count;              // Words held
  logic             push;
  logic             pop;

  // Handshakes are combinational; full and empty come from count
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = in_valid && in_ready && clk_en;
  assign pop       = out_valid && out_ready && clk_en;
  assign out_data  = mem[rd_ptr];

  // Storage array has no reset; only pointers and count need a defined start
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  // Pointer and count update
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1);
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1);
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // pport_fifo

// *** core/pport_device.sv ***
// Printer port device end: DMA request, pin sharing and selector routing
// Contract
// - Raise DMA request when transfer needed.
// - Request pin floats unless extended mode and DMA.
// - Request signals only in extended mode.
// - Controller acknowledges low, enabling DMA strobes.
// - Shared pin is acknowledge or identity by bit.
// - Unused shared function reads constant one.
// - Acknowledge honoured only in extended mode.
// - Selector pin or drive-two input by bit.
// - Selector routes pins to printer or floppy.
// - Floppy mode supplies extra raw read data.
// - Printer drives paper end high when empty.
// - Printer drives select high when connected.
// - Select-input output follows control bit, low selects.
// - Control bit zero floats select-input pin.
// - Read strobe treated as active low.
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
module pport_device #(
  parameter int DEPTH = pport_pkg::FIFO_DEPTH
)(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  pport_if.device         link,
  input  wire logic [3:0] sw_addr,
  input  wire logic [7:0] sw_wdata,
  input  wire logic       sw_wr,
  input  wire logic       sw_rd,
  output logic      [7:0] sw_rdata,
  output logic            ident_sel,
  output logic            drive_two_in,
  output logic            floppy_raw_rdata,
  output logic      [7:0] dma_rx_data,
  output logic            dma_rx_valid
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,   // Nothing to move
    ST_REQ  = 3'b010,   // Request raised, waiting for acknowledge
    ST_XFER = 3'b100    // Acknowledge seen, waiting for strobe
  } dma_state_t;

  typedef struct packed {
    logic [7:0] port_ctrl_reg;     // Mode and pin control
    logic [7:0] power_mgmt_ctrl;   // DMA configuration
    logic [7:0] floppy_cfg_reg;    // Selector pin role
    logic [7:0] rdata;             // Read data, one cycle later
    dma_state_t state;             // DMA handshake state
    logic [7:0] out_byte;          // Byte on the port data pins
    logic [1:0] ack_s;             // Shared pin synchroniser
    logic [1:0] rd_s;              // Read strobe synchroniser
    logic [1:0] wr_s;              // Write strobe synchroniser
    logic [1:0] pe_s;              // Paper end synchroniser
    logic [1:0] printer_selected_s;            // Select status synchroniser
    logic [1:0] pnf_s;             // Selector pin synchroniser
    logic [1:0] frd_s;             // Floppy read data synchroniser
    logic       rd_prev;           // Strobe edge history
    logic       wr_prev;
    logic [7:0] rx_data;           // Byte taken on DMA write
    logic       rx_valid;          // One-cycle pulse with rx_data
  } dev_state_t;

  dev_state_t st;
  dev_state_t next_st;

  logic       ecp_on;              // Extended mode enabled
  logic       dma_cfg;             // DMA configured
  logic       ack_n_eff;           // Acknowledge as seen by logic
  logic       printer_mode;        // Pins belong to printer
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic       fifo_pop;
  logic       sw_push;

  // Decoded modes
  assign ecp_on  = st.port_ctrl_reg[pport_pkg::ECP_EN_BIT];
  assign dma_cfg = st.power_mgmt_ctrl[pport_pkg::DMA_CFG_BIT];
  // Shared pin role; the unused role reads as one
  assign ack_n_eff = dma_cfg ? st.ack_s[1] : 1'b1;
  assign ident_sel = dma_cfg ? 1'b1 : st.ack_s[1];
  // Selector pin role: selector, else drive-two input; default printer
  assign printer_mode = st.floppy_cfg_reg[pport_pkg::PNF_EN_BIT]
                        ? st.pnf_s[1] : 1'b1;
  assign drive_two_in = st.floppy_cfg_reg[pport_pkg::PNF_EN_BIT]
                        ? 1'b1 : st.pnf_s[1];
  assign floppy_raw_rdata = printer_mode ? 1'b1 : st.frd_s[1];

  assign sw_push  = sw_wr && (sw_addr == pport_pkg::OFS_DATA);
  assign fifo_pop = (st.state == ST_XFER) && st.rd_prev && !st.rd_s[1];

  // Bytes from software wait here until the controller fetches them
  pport_fifo #(
    .WIDTH     (8),
    .DEPTH     (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .clk_en    (clk_en),
    .in_valid  (sw_push),
    .in_ready  (fifo_in_ready),
    .in_data   (sw_wdata),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // Pin outputs; printer drive is withdrawn in floppy mode
  always_comb
  begin
    link.printer_dma_req    = (st.state == ST_REQ);
    link.printer_dma_req_oe = ecp_on && dma_cfg;
    link.port_data_out      = st.out_byte;
    link.port_data_oe       = printer_mode ? 8'hFF : 8'h00;
    link.select_input_n_out = 1'b0;
    link.select_input_n_oe  = printer_mode
                              && st.port_ctrl_reg[pport_pkg::SEL_CTRL_BIT];
  end

  // Next-state logic for the whole device
  always_comb
  begin
    next_st          = st;
    next_st.rx_valid = 1'b0;
    // Two flip-flops on every pin input but dma_data; only stage 1 reads stage 0
    next_st.ack_s  = {st.ack_s[0],  link.shared_ack_pin};
    next_st.rd_s   = {st.rd_s[0],   link.dma_rd_n};
    next_st.wr_s   = {st.wr_s[0],   link.dma_wr_n};
    next_st.pe_s   = {st.pe_s[0],   link.paper_end};
    next_st.printer_selected_s = {st.printer_selected_s[0], link.printer_selected};
    next_st.pnf_s  = {st.pnf_s[0],  link.printer_not_floppy_sel};
    next_st.frd_s  = {st.frd_s[0],  link.floppy_rdata};
    next_st.rd_prev = st.rd_s[1];
    next_st.wr_prev = st.wr_s[1];
    // Software register writes
    if (sw_wr)
    begin
      unique case (sw_addr)
        pport_pkg::OFS_PORT_CTRL:  next_st.port_ctrl_reg   = sw_wdata;
        pport_pkg::OFS_PWR_MGMT:   next_st.power_mgmt_ctrl = sw_wdata;
        pport_pkg::OFS_FLOPPY_CFG: next_st.floppy_cfg_reg  = sw_wdata;
        default: ;
      endcase
    end
    // Software reads, answered one cycle later
    next_st.rdata = 8'h00;
    if (sw_rd)
    begin
      unique case (sw_addr)
        pport_pkg::OFS_PORT_CTRL:  next_st.rdata = st.port_ctrl_reg;
        pport_pkg::OFS_PWR_MGMT:   next_st.rdata = st.power_mgmt_ctrl;
        pport_pkg::OFS_FLOPPY_CFG: next_st.rdata = st.floppy_cfg_reg;
        pport_pkg::OFS_STATUS:
          next_st.rdata = {2'h0, fifo_in_ready, fifo_out_valid,
                           printer_mode, st.printer_selected_s[1],
                           st.pe_s[1], 1'b0};
        default: next_st.rdata = 8'h00;
      endcase
    end
    // DMA handshake; leaving extended mode or DMA drops any request
    unique case (st.state)
      ST_IDLE:
        if (ecp_on && dma_cfg && printer_mode && fifo_out_valid)
          next_st.state = ST_REQ;
      ST_REQ:
        if (!ecp_on || !dma_cfg)
          next_st.state = ST_IDLE;
        else if (!ack_n_eff)
          next_st.state = ST_XFER;
      ST_XFER:
      begin
        if (!ecp_on || !dma_cfg || ack_n_eff)
          next_st.state = ST_IDLE;
        else if (fifo_pop)
        begin
          // Falling edge of the active-low read strobe moves a byte
          next_st.out_byte = fifo_out_data;
          next_st.state    = ST_IDLE;
        end
        else if (st.wr_prev && !st.wr_s[1])
        begin
          next_st.rx_data  = link.dma_data;
          next_st.rx_valid = 1'b1;
          next_st.state    = ST_IDLE;
        end
      end
    endcase
  end

  assign sw_rdata     = st.rdata;
  assign dma_rx_data  = st.rx_data;
  assign dma_rx_valid = st.rx_valid;

  // State register; all of it freezes while clk_en is low
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st                 <= '0;
      st.port_ctrl_reg   <= pport_pkg::PORT_CTRL_RST;
      st.power_mgmt_ctrl <= pport_pkg::PWR_MGMT_RST;
      st.floppy_cfg_reg  <= pport_pkg::FLOPPY_CFG_RST;
      st.state           <= ST_IDLE;
      st.ack_s           <= 2'h3;
      st.rd_s            <= 2'h3;
      st.wr_s            <= 2'h3;
      st.rd_prev         <= 1'b1;
      st.wr_prev         <= 1'b1;
    end
    else if (clk_en)
      st <= next_st;
  end
endmodule // pport_device

// *** core/pport_host.sv ***
// Far end: DMA controller and printer pins driving the device link
`timescale 1ns/1ps
module pport_host (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  pport_if.host           link,
  input  wire logic       use_dma_ack,
  input  wire logic       ident_level,
  input  wire logic       out_of_paper,
  input  wire logic       connected,
  input  wire logic       floppy_mode,
  input  wire logic       raw_rdata,
  input  wire logic       do_write,
  input  wire logic [7:0] write_byte,
  output logic      [7:0] read_byte,
  output logic            read_done
);
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,  // Waiting for a request
    H_ACK  = 4'b0010,  // Acknowledge low, strobe next
    H_STB  = 4'b0100,  // Strobe low
    H_DONE = 4'b1000   // Waiting for the served request to drop
  } host_state_t;

  typedef struct packed {
    host_state_t state;
    logic [1:0]  req_s;    // Request synchroniser
    logic        ack_n;    // Acknowledge pin level
    logic        rd_n;
    logic        wr_n;
    logic        is_write;
    logic [7:0]  rbyte;
    logic        rdone;
  } host_st_t;

  host_st_t st;
  host_st_t next_st;

  // Pins; unused shared role held at identity level
  always_comb
  begin
    link.shared_ack_pin         = use_dma_ack ? st.ack_n : ident_level;
    link.dma_rd_n               = st.rd_n;
    link.dma_wr_n               = st.wr_n;
    link.dma_data               = write_byte;
    link.paper_end              = out_of_paper;
    link.printer_selected       = connected;
    link.printer_not_floppy_sel = !floppy_mode;
    link.floppy_rdata           = raw_rdata;
  end

  // Acknowledge low, then one strobe, then release
  always_comb
  begin
    next_st       = st;
    next_st.rdone = 1'b0;
    next_st.req_s = {st.req_s[0],
                     link.printer_dma_req && link.printer_dma_req_oe};
    unique case (st.state)
      H_IDLE:
        if (st.req_s[1])
        begin
          next_st.ack_n    = 1'b0;
          next_st.is_write = do_write;
          next_st.state    = H_ACK;
        end
      H_ACK:
      begin
        if (st.is_write)
          next_st.wr_n = 1'b0;
        else
          next_st.rd_n = 1'b0;
        next_st.state = H_STB;
      end
      H_STB:
      begin
        if (!st.is_write)
        begin
          next_st.rbyte = link.port_data_out;
          next_st.rdone = 1'b1;
        end
        next_st.rd_n  = 1'b1;
        next_st.wr_n  = 1'b1;
        next_st.ack_n = 1'b1;
        next_st.state = H_DONE;
      end
      // The synchroniser still shows the served request for a while;
      // acking that stale level would start a transfer nobody asked for
      H_DONE:
        if (!st.req_s[1])
          next_st.state = H_IDLE;
    endcase
  end

  assign read_byte = st.rbyte;
  assign read_done = st.rdone;

  // State register, frozen while clk_en is low
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st       <= '0;
      st.state <= H_IDLE;
      st.ack_n <= 1'b1;
      st.rd_n  <= 1'b1;
      st.wr_n  <= 1'b1;
    end
    else if (clk_en)
      st <= next_st;
  end
endmodule // pport_host

// *** dv/pport_asserts.sv ***
// Concurrent checks on the printer-port link between the two ends
`timescale 1ns/1ps
module pport_asserts (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       printer_dma_req,
  input wire logic       printer_dma_req_oe,
  input wire logic       shared_ack_pin,
  input wire logic       dma_rd_n,
  input wire logic       dma_wr_n,
  input wire logic [7:0] port_data_oe,
  input wire logic       select_input_n_out,
  input wire logic       select_input_n_oe
);
  // One clock domain, so one clocking and one disable for all
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // A request may only start while the pin is driven
  chk_req_when_driven: assert property (
    $rose(printer_dma_req) |-> printer_dma_req_oe)
    else $error("request rose while pin floated");
  // Out of extended mode the request must die within two cycles
  chk_req_off_mode: assert property (
    !printer_dma_req_oe [*3] |-> !printer_dma_req)
    else $error("request held outside extended mode");
  // An honoured acknowledge ends the pending request
  chk_ack_ends_req: assert property (
    $fell(shared_ack_pin) && printer_dma_req && printer_dma_req_oe
    |-> ##[1:8] !printer_dma_req)
    else $error("request not withdrawn after acknowledge");
  // Acknowledge is followed by one transfer strobe
  chk_ack_strobe: assert property (
    $fell(shared_ack_pin) && printer_dma_req_oe
    |-> ##[1:4] (!dma_rd_n || !dma_wr_n))
    else $error("acknowledge without transfer strobe");
  // Strobes only count as DMA strobes under acknowledge
  chk_strobe_acked: assert property (
    !dma_rd_n || !dma_wr_n |-> !shared_ack_pin)
    else $error("strobe without acknowledge");
  // Read and write strobes never overlap
  chk_strobe_excl: assert property (
    !dma_rd_n |-> dma_wr_n)
    else $error("read and write strobes overlap");
  // Floppy routing drops every printer-side drive
  chk_floppy_quiet: assert property (
    port_data_oe != 8'hFF
    |-> port_data_oe == 8'h00 && !select_input_n_oe)
    else $error("printer drive in floppy mode");
  // Select-input is only ever driven low
  chk_sel_low: assert property (
    select_input_n_oe |-> !select_input_n_out)
    else $error("select-input driven high");
endmodule // pport_asserts

// *** dv/test_printer_port_dma_and_pin_share.sv ***
// Self-checking bench for the printer-port link with both ends joined
`timescale 1ns/1ps
module test_printer_port_dma_and_pin_share;
  logic       clk;          // 125 MHz system clock
  logic       reset_n;      // Asynchronous reset, active low
  logic       clk_en;       // Freezes both ends while low
  logic [3:0] sw_addr;      // Software port address
  logic [7:0] sw_wdata;     // Software write data
  logic       sw_wr;        // Write strobe
  logic       sw_rd;        // Read strobe
  logic [7:0] sw_rdata;     // Read data, cycle after strobe
  logic       ident_sel;    // Identity-select as seen inside
  logic       drive_two_in; // Drive-two input as seen inside
  logic       floppy_raw_rdata;
  logic [7:0] dma_rx_data;  // Byte from a DMA write
  logic       dma_rx_valid;
  logic       use_dma_ack, ident_level, out_of_paper, connected;
  logic       floppy_mode, raw_rdata, do_write, read_done;
  logic [7:0] write_byte, read_byte;
  logic [7:0] rd;           // Last value read over software port
  int         bad_count, check_count, cycles, dones, rx_seen;

  pport_if u_pport_if ();
  pport_device #(.DEPTH(8)) u_pport_device (.clk(clk), .reset_n(reset_n),
    .clk_en(clk_en), .link(u_pport_if.device), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
    .ident_sel(ident_sel), .drive_two_in(drive_two_in),
    .floppy_raw_rdata(floppy_raw_rdata), .dma_rx_data(dma_rx_data),
    .dma_rx_valid(dma_rx_valid));
  pport_host u_pport_host (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
    .link(u_pport_if.host), .use_dma_ack(use_dma_ack),
    .ident_level(ident_level), .out_of_paper(out_of_paper),
    .connected(connected), .floppy_mode(floppy_mode), .raw_rdata(raw_rdata),
    .do_write(do_write), .write_byte(write_byte), .read_byte(read_byte),
    .read_done(read_done));
  pport_asserts u_pport_asserts (.clk(clk), .reset_n(reset_n),
    .printer_dma_req(u_pport_if.printer_dma_req),
    .printer_dma_req_oe(u_pport_if.printer_dma_req_oe),
    .shared_ack_pin(u_pport_if.shared_ack_pin),
    .dma_rd_n(u_pport_if.dma_rd_n), .dma_wr_n(u_pport_if.dma_wr_n),
    .port_data_oe(u_pport_if.port_data_oe),
    .select_input_n_out(u_pport_if.select_input_n_out),
    .select_input_n_oe(u_pport_if.select_input_n_oe));

  // Free-running clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Count completions and cut a hang short; 20000 is far above need
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (read_done === 1'b1) dones <= dones + 1;
    if (dma_rx_valid === 1'b1) rx_seen <= rx_seen + 1;
    if (cycles == 20000)
    begin
      bad_count++;
      $display("ERROR %0t: timeout", $time);
      end_of_test();
    end
  end

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // One-cycle write on the software port
  task automatic sw_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    sw_addr  <= a;
    sw_wdata <= d;
    sw_wr    <= 1'b1;
    @(posedge clk);
    sw_wr    <= 1'b0;
    // One more edge so the written state is settled for the caller
    @(posedge clk);
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle read; data taken in the following cycle only
  task automatic reg_check(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    sw_addr <= a;
    sw_rd   <= 1'b1;
    @(posedge clk);
    sw_rd   <= 1'b0;
    #1 rd = sw_rdata;
    check(rd, exp);
    // Return on an edge so callers drive stimulus there
    @(posedge clk);
  endtask

  // Pins pass two flops before the device sees them
  task automatic settle;
    repeat (6) @(posedge clk);
  endtask

  initial
  begin
    {reset_n, sw_addr, sw_wdata, sw_wr, sw_rd} = '0;
    {use_dma_ack, ident_level, out_of_paper, connected} = '0;
    {floppy_mode, raw_rdata, do_write, write_byte} = '0;
    {cycles, dones, rx_seen, bad_count, check_count} = '0;
    clk_en = 1'b1;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    // Reset values, unmapped read, idle pin enables
    reg_check(pport_pkg::OFS_PORT_CTRL, pport_pkg::PORT_CTRL_RST);
    reg_check(pport_pkg::OFS_PWR_MGMT, pport_pkg::PWR_MGMT_RST);
    reg_check(pport_pkg::OFS_FLOPPY_CFG, pport_pkg::FLOPPY_CFG_RST);
    reg_check(pport_pkg::OFS_STATUS, 8'h28);
    reg_check(4'hF, 8'h00);
    check({6'h00, u_pport_if.printer_dma_req_oe,
           u_pport_if.select_input_n_oe}, 8'h00);
    $display("Test reset done");
    // Shared pin as identity, then as acknowledge
    settle();
    check({7'h00, ident_sel}, 8'h00);
    ident_level <= 1'b1;
    settle();
    check({7'h00, ident_sel}, 8'h01);
    sw_write(pport_pkg::OFS_PWR_MGMT, 8'h08);
    // Pin held low: only the constant-one rule keeps identity high
    ident_level <= 1'b0;
    settle();
    check({7'h00, ident_sel}, 8'h01);
    use_dma_ack <= 1'b1;
    // Request pin drive needs both enables
    check({7'h00, u_pport_if.printer_dma_req_oe}, 8'h00);
    sw_write(pport_pkg::OFS_PORT_CTRL, 8'h04);
    check({7'h00, u_pport_if.printer_dma_req_oe}, 8'h01);
    check({7'h00, u_pport_if.printer_dma_req}, 8'h00);
    sw_write(pport_pkg::OFS_PWR_MGMT, 8'h00);
    check({7'h00, u_pport_if.printer_dma_req_oe}, 8'h00);
    sw_write(pport_pkg::OFS_PWR_MGMT, 8'h08);
    sw_write(pport_pkg::OFS_PORT_CTRL, 8'h08);
    // Printer status and select-input
    out_of_paper <= 1'b1;
    connected    <= 1'b1;
    settle();
    reg_check(pport_pkg::OFS_STATUS, 8'h2E);
    check({6'h00, u_pport_if.select_input_n_oe,
           u_pport_if.select_input_n_out}, 8'h02);
    $display("Test pins done");
    // Selector role off: pin is drive-two; then selector role on
    floppy_mode <= 1'b1;
    settle();
    check({7'h00, drive_two_in}, 8'h00);
    sw_write(pport_pkg::OFS_FLOPPY_CFG, 8'h04);
    settle();
    check({7'h00, drive_two_in}, 8'h01);
    check(u_pport_if.port_data_oe, 8'h00);
    check({7'h00, u_pport_if.select_input_n_oe}, 8'h00);
    reg_check(pport_pkg::OFS_STATUS, 8'h26);
    raw_rdata <= 1'b1;
    settle();
    check({7'h00, floppy_raw_rdata}, 8'h01);
    raw_rdata <= 1'b0;
    settle();
    check({7'h00, floppy_raw_rdata}, 8'h00);
    floppy_mode <= 1'b0;
    settle();
    check(u_pport_if.port_data_oe, 8'hFF);
    sw_write(pport_pkg::OFS_PORT_CTRL, 8'h00);
    check({7'h00, u_pport_if.select_input_n_oe}, 8'h00);
    // A write while the clock enable is low must be lost
    clk_en <= 1'b0;
    sw_write(pport_pkg::OFS_PORT_CTRL, 8'h08);
    clk_en <= 1'b1;
    reg_check(pport_pkg::OFS_PORT_CTRL, 8'h00);
    $display("Test selector done");
    // Fill buffer with requests off; the ninth byte is refused
    for (int i = 0; i < 9; i++)
      sw_write(pport_pkg::OFS_DATA, 8'(i * 17));
    reg_check(pport_pkg::OFS_STATUS, 8'h1E);
    settle();
    check({7'h00, u_pport_if.printer_dma_req}, 8'h00);
    // Enable extended mode: eight read transfers drain it
    sw_write(pport_pkg::OFS_PORT_CTRL, 8'h04);
    for (int k = 0; k < 400 && dones < 8; k++) @(posedge clk);
    settle();
    check(8'(dones), 8'h08);
    check(u_pport_if.port_data_out, 8'h77);
    // Host samples before the device updates, so it holds the 7th byte
    check(read_byte, 8'h66);
    reg_check(pport_pkg::OFS_STATUS, 8'h2E);
    check({7'h00, u_pport_if.printer_dma_req}, 8'h00);
    // One write transfer carries a host byte in
    do_write   <= 1'b1;
    write_byte <= 8'hA5;
    sw_write(pport_pkg::OFS_DATA, 8'h5A);
    for (int k = 0; k < 100 && rx_seen == 0; k++) @(posedge clk);
    check(dma_rx_data, 8'hA5);
    sw_write(pport_pkg::OFS_PORT_CTRL, 8'h00);
    $display("Test transfer done");
    end_of_test();
  end
endmodule // test_printer_port_dma_and_pin_share
